// file: clock_prescaler_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock prescaler
`ifndef CLOCK_PRESCALER_DEFINES_SVH
`define CLOCK_PRESCALER_DEFINES_SVH

`define CDC_OFFSET        12'h028
`define TRIM_OFFSET       12'h02C
`define CDC_CE_BIT        7
`define CDC_SEL_MSB       3
`define SEL_RESET_PLAIN   4'h0
`define SEL_RESET_DIV8    4'h3
`define SEL_MAX_CODE      4'h8
`define CE_WINDOW_CYCLES  3'h4
`define TRIM_DEFAULT      8'h80

`endif

// file: clock_prescaler_pkg.sv
// Types shared by the clock prescaler
`default_nettype none
package clock_prescaler_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    SRC_RC,
    SRC_WDT,
    SRC_PLL,
    SRC_CRYSTAL
  } clock_source_t;

  typedef struct packed {
    logic        change_enable;
    logic [2:0]  window_count;
    logic [3:0]  divider_select;
    logic [3:0]  pending_select;
    logic        pending;
    logic [8:0]  ripple;
    logic        sys_clk_en;
    logic [7:0]  trim_value;
    logic        clock_out;
    apb_rsp_t    rsp;
  } prescaler_state_t;

endpackage
`default_nettype wire

// file: system_clock_prescaler_calibration.sv
// System clock prescaler with protected change sequence, oscillator trim and clock output
//
// Functional notes
// - New rate active within one new period
// - Clock output only with option, non-crystal
// - Clock output quiet during reset
// - Clock output option overrides pin GPIO
// - Clock output not for crystal source
// - Output pin carries divided system clock
// - Factory trim loaded at reset
// - Trim writable, retunes oscillator at once
// - Top trim bit selects overlapping range
// - Low seven trim bits tune monotonically
// - Divider changes only while enable set
// - Enable set only with other bits zero
// - Enable clears after four cycles or write
// - Rewriting enable neither restarts nor clears
// - Bits six to four read zero
// - Divider factor is two to code
// - Reset divider from divide-by-eight option
// - Any legal divider accepted after sequence
// - No glitch, no overspeed during change
// - Divided clock feeds all synchronous domains
`default_nettype none
`include "clock_prescaler_defines.svh"
module system_clock_prescaler_calibration
  import clock_prescaler_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = `TRIM_DEFAULT
)(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire apb_req_t      apb_req,
  output      apb_rsp_t      apb_rsp,
  input  wire logic          divide_by_eight_option,
  input  wire logic          clock_output_option,
  input  wire clock_source_t clock_source,
  input  wire logic          gpio_out,
  input  wire logic          gpio_oe,
  output      logic          sys_clk_en,
  output      logic [7:0]    trim_value,
  output      logic          clock_output_pin_out,
  output      logic          clock_output_pin_oe
);

  prescaler_state_t state;
  prescaler_state_t next_state;

  // Division factor is two to the code; reserved codes never reach here
  function automatic logic tick_due(input logic [3:0] sel, input logic [8:0] cnt);
    logic [8:0] mask;
    mask = 9'h000;
    if (sel != 4'h0)
    begin
      mask = 9'(({1'b0, 9'h1FF} >> (4'd9 - sel)));
    end
    tick_due = ((cnt & mask) == mask);
  endfunction

  logic        access;
  logic        ack;
  logic        wr;
  logic        hit_cdc;
  logic        hit_trim;
  logic [7:0]  wbyte;
  logic        clkout_allowed;

  always_comb
  begin
    access         = apb_req.psel && apb_req.penable;
    // One wait state so read data stands in a flip-flop at the ready edge
    ack            = access && state.rsp.pready;
    wr             = ack && apb_req.pwrite;
    hit_cdc        = (apb_req.paddr == `CDC_OFFSET);
    hit_trim       = (apb_req.paddr == `TRIM_OFFSET);
    wbyte          = apb_req.pwdata[7:0];
    clkout_allowed = clock_output_option && (clock_source != SRC_CRYSTAL);
  end

  always_comb
  begin
    next_state = state;
    next_state.rsp = '0;

    // Enable window counts down; timeout clears it
    if (state.change_enable)
    begin
      if (state.window_count == 3'h1)
      begin
        next_state.change_enable = 1'b0;
        next_state.window_count  = 3'h0;
      end
      else
      begin
        next_state.window_count = state.window_count - 3'h1;
      end
    end

    if (access && !state.rsp.pready)
    begin
      next_state.rsp.pready  = 1'b1;
      next_state.rsp.pslverr = !(hit_cdc || hit_trim);
      if (hit_cdc)
      begin
        next_state.rsp.prdata = {24'h0, state.change_enable, 3'b000, state.divider_select};
      end
      else if (hit_trim)
      begin
        next_state.rsp.prdata = {24'h0, state.trim_value};
      end
    end

    if (wr && hit_cdc)
    begin
      if (wbyte == 8'h80)
      begin
        // Rewrite inside window leaves the countdown alone
        if (!state.change_enable)
        begin
          next_state.change_enable = 1'b1;
          next_state.window_count  = `CE_WINDOW_CYCLES;
        end
      end
      else if (!wbyte[`CDC_CE_BIT] && state.change_enable)
      begin
        next_state.change_enable = 1'b0;
        next_state.window_count  = 3'h0;
        if (wbyte[`CDC_SEL_MSB:0] <= `SEL_MAX_CODE)
        begin
          next_state.divider_select = wbyte[`CDC_SEL_MSB:0];
          next_state.pending_select = wbyte[`CDC_SEL_MSB:0];
          next_state.pending        = 1'b1;
        end
      end
    end

    if (wr && hit_trim)
    begin
      next_state.trim_value = wbyte;
    end

    // Ripple counter on the master clock; the new rate takes over only at
    // a new-rate tick of the counter, so the switch waits at most one new period
    next_state.ripple     = state.ripple + 9'h001;
    next_state.sys_clk_en = 1'b0;
    if (tick_due(state.pending ? state.pending_select : state.divider_select, state.ripple)
        || tick_due(state.divider_select, state.ripple) && !state.pending)
    begin
      next_state.sys_clk_en = 1'b1;
    end
    if (state.pending && tick_due(state.pending_select, state.ripple))
    begin
      // Switch ends at a new-rate tick; counter restarts for the new period
      next_state.pending    = 1'b0;
      next_state.ripple     = 9'h000;
      next_state.sys_clk_en = 1'b1;
    end

    // Toggle output on each divided tick, giving the divided clock
    if (clkout_allowed && state.sys_clk_en)
    begin
      next_state.clock_out = !state.clock_out;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state                <= '0;
      state.divider_select <= divide_by_eight_option ? `SEL_RESET_DIV8 : `SEL_RESET_PLAIN;
      state.trim_value     <= FACTORY_TRIM;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_comb
  begin
    apb_rsp    = state.rsp;
    sys_clk_en = state.sys_clk_en;
    trim_value = state.trim_value;
    // Pin held low in reset while clock output allowed; option takes the pin from GPIO unless crystal
    clock_output_pin_out = clkout_allowed ? (state.clock_out && !srst) : gpio_out;
    clock_output_pin_oe  = clkout_allowed ? 1'b1 : gpio_oe;
  end

endmodule
`default_nettype wire

// file: prescaler_checker_assertions.sv
// Assertion checker for the clock prescaler
`default_nettype none
`include "clock_prescaler_defines.svh"
module prescaler_checker
  import clock_prescaler_pkg::*;
#(parameter logic [7:0] FACTORY_TRIM = 8'h80)(
  input wire logic          clk,
  input wire logic          srst,
  input wire apb_req_t      apb_req,
  input wire apb_rsp_t      apb_rsp,
  input wire logic          clock_output_option,
  input wire clock_source_t clock_source,
  input wire logic          gpio_out,
  input wire logic          sys_clk_en,
  input wire logic [7:0]    trim_value,
  input wire logic          clock_output_pin_out,
  input wire logic          clock_output_pin_oe
);
  logic [9:0] gap;
  logic       wr, xtal, on;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  assign xtal = clock_source == SRC_CRYSTAL;
  assign on = clock_output_option && !xtal;
  // Loose bound: a rate switch may stretch one gap
  always_ff @(posedge clk) gap <= (srst || sys_clk_en) ? 10'h000 : gap + 10'h001;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_trim_reset: assert property ($past(srst) |-> trim_value == FACTORY_TRIM)
    else $error("trim not factory after reset");
  a_trim_write: assert property ($changed(trim_value)
    |-> $past(wr && apb_req.paddr == `TRIM_OFFSET)) else $error("trim moved unwritten");
  a_pin_quiet: assert property ($past(srst && on) |-> !clock_output_pin_out)
    else $error("pin active in reset");
  a_tick_reset: assert property ($past(srst) |-> !sys_clk_en)
    else $error("tick in reset");
  a_xtal_quiet: assert property (xtal && $past(xtal) && $stable(gpio_out)
    |-> $stable(clock_output_pin_out)) else $error("clock on crystal pin");
  a_pin_clock: assert property (on && $past(on) && $past(on, 2)
    |-> clock_output_pin_oe && ($stable(clock_output_pin_out) || sys_clk_en
    || $past(sys_clk_en))) else $error("pin not divided clock");
  a_clock_alive: assert property (gap < 10'd512)
    else $error("divided clock stalled");
  a_rsvd_zero: assert property (apb_req.psel && apb_req.penable && !apb_req.pwrite
    && apb_rsp.pready && apb_req.paddr == `CDC_OFFSET |-> apb_rsp.prdata[6:4] == 3'h0)
    else $error("rsvd set");
endmodule
`default_nettype wire

// file: system_clock_prescaler_calibration_tb_top.sv
// Testbench for the clock prescaler
`default_nettype none
`include "clock_prescaler_defines.svh"
module system_clock_prescaler_calibration_tb_top
  import clock_prescaler_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] FT = 8'h5A;  // Arbitrary factory trim
  logic clk = 0, srst = 1, div8 = 1, opt = 0, gout = 0, goe = 0, err, v, tick, pout, poe;
  clock_source_t src = SRC_RC;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [7:0] trim;
  logic [31:0] q;
  int n_mismatch = 0, checked = 0;
  always #5 clk = ~clk;
  system_clock_prescaler_calibration #(.FACTORY_TRIM(FT)) dut (.clk(clk), .srst(srst),
    .apb_req(req), .apb_rsp(rsp), .divide_by_eight_option(div8), .clock_output_option(opt),
    .clock_source(src), .gpio_out(gout), .gpio_oe(goe), .sys_clk_en(tick),
    .trim_value(trim), .clock_output_pin_out(pout), .clock_output_pin_oe(poe));
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] seen, logic [31:0] e);
    checked++;
    if (seen !== e)
    begin
      $display("[FAIL] %s exp %h got %h", s, e, seen);
      n_mismatch++;
    end
  endtask
  // Data taken at the ready edge; one idle edge keeps the enable window open
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (rsp.pready !== 1'b1 && i < 20);
    if (rsp.pready !== 1'b1)
    begin
      n_mismatch++;
      final_report();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd_div(logic [31:0] e);
    bus(0, `CDC_OFFSET, 0);
    chk("divider", q, e);
  endtask
  task automatic tick_gap(int e);
    int c, k;
    for (k = 0; k < 3; k++)
    begin
      c = 0;
      do @(posedge clk); while (tick !== 1'b1 && ++c < 600);
    end
    if (c >= 600)
    begin
      n_mismatch++;
      final_report();
    end
    chk("tick gap", c + 1, e);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 0;
    rd_div(3);
    bus(0, `TRIM_OFFSET, 0);
    chk("trim rst", q, FT);
    tick_gap(8);
    bus(0, 12'h010, 0);
    chk("unmapped", err, 1);
    bus(1, `CDC_OFFSET, 5);
    rd_div(3);
    bus(1, `CDC_OFFSET, 32'h81);
    bus(1, `CDC_OFFSET, 5);
    rd_div(3);
    bus(1, `CDC_OFFSET, 32'h80);
    repeat (6) @(posedge clk);
    bus(1, `CDC_OFFSET, 5);
    rd_div(3);
    bus(1, `CDC_OFFSET, 32'h80);
    bus(1, `CDC_OFFSET, 32'h80);
    bus(1, `CDC_OFFSET, 2);
    rd_div(3);
    bus(1, `CDC_OFFSET, 32'h80);
    bus(1, `CDC_OFFSET, 0);
    rd_div(0);
    tick_gap(1);
    bus(1, `CDC_OFFSET, 32'h80);
    bus(1, `CDC_OFFSET, 9);
    rd_div(0);
    bus(1, `TRIM_OFFSET, 32'h7F);
    chk("trim port", trim, 8'h7F);
    opt <= 1;
    repeat (3) @(posedge clk);
    v = pout;
    @(posedge clk) chk("pin toggle", pout, !v);
    chk("pin oe", poe, 1);
    src <= SRC_CRYSTAL;
    repeat (3) @(posedge clk);
    v = pout;
    @(posedge clk) chk("xtal pin", pout, v);
    src <= SRC_RC;
    opt <= 0;
    goe <= 1;
    gout <= 1;
    repeat (3) @(posedge clk);
    chk("gpio pin", {poe, pout}, 2'b11);
    opt <= 1;
    div8 <= 0;
    srst <= 1;
    repeat (3) @(posedge clk);
    chk("pin in reset", pout, 0);
    srst <= 0;
    rd_div(0);
    bus(1, `CDC_OFFSET, 32'h80);
    bus(1, `CDC_OFFSET, 8);
    tick_gap(256);
    final_report();
  end
endmodule
bind system_clock_prescaler_calibration prescaler_checker #(.FACTORY_TRIM(FACTORY_TRIM)) chk_u (
  .clk(clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp), .gpio_out(gpio_out),
  .clock_output_option(clock_output_option), .clock_source(clock_source),
  .sys_clk_en(sys_clk_en), .trim_value(trim_value), .clock_output_pin_out(clock_output_pin_out),
  .clock_output_pin_oe(clock_output_pin_oe));
`default_nettype wire
